// ---- lcac_pkg.sv ----
// Purpose: shared constants and types for the logic cell arithmetic chains
// Assumes: one logic array cluster of eight adaptive logic cells
// Notes:   byte offsets of the control port, field layouts, reset values
`default_nettype none
package lcac_pkg;

    // ************************************************************
    // cluster shape
    // ************************************************************
    localparam int LCAC_CELLS = 8;            // cells per cluster
    localparam int LCAC_HALF  = 4;            // cells per half
    localparam int LCAC_BITS  = 16;           // two adders per cell

    // ************************************************************
    // control port map, byte addresses
    // ************************************************************
    localparam logic [3:0] LCAC_OFS_CTRL   = 4'h0; // modes, span, starts
    localparam logic [3:0] LCAC_OFS_DSEL   = 4'h4; // register data select
    localparam logic [3:0] LCAC_OFS_CLRSEL = 4'h8; // clear line per register
    localparam logic [3:0] LCAC_OFS_STATUS = 4'hc; // register and carry view

    // ************************************************************
    // control word fields
    // ************************************************************
    localparam int LCAC_F_UMODE = 0;          // upper mode, two bits
    localparam int LCAC_F_LMODE = 2;          // lower mode, two bits
    localparam int LCAC_F_HALVES = 4;         // 1: two half chains
    localparam int LCAC_F_BEG_U = 5;          // chain starts at cell 0
    localparam int LCAC_F_BEG_L = 6;          // chain starts at cell 4
    localparam int LCAC_F_ROUTE = 16;         // status: routed carries
    localparam logic [6:0] LCAC_CTRL_RST = 7'h60; // normal, full, starts
    localparam logic [31:0] LCAC_DSEL_RST = 32'h0000_0000;
    localparam logic [15:0] LCAC_CLRSEL_RST = 16'h0000;

    // cell operating modes, code 2'b11 is illegal
    typedef enum logic [1:0] {
        LCAC_NORMAL = 2'b00,
        LCAC_ARITH  = 2'b01,
        LCAC_SHARED = 2'b10
    } lcac_mode_t;

    // register data source, code 2'b11 is illegal
    typedef enum logic [1:0] {
        LCAC_D_SUM   = 2'b00,
        LCAC_D_CHAIN = 2'b01,
        LCAC_D_PACK  = 2'b10
    } lcac_dsel_t;

endpackage
`default_nettype wire

// ---- lcac_cell_adders.sv ----
// Purpose: lookup tables and the two dedicated adders of one cell
// Assumes: combinational, mode held steady by the cluster
// Notes:   normal mode passes the carry through for half bypass
`timescale 1ns/1ns
`default_nettype none
module lcac_cell_adders
    import lcac_pkg::*;
(
    input  wire lcac_mode_t mode,        // cell operating mode
    input  wire logic [1:0] op_a,        // operand a, two bits
    input  wire logic [1:0] op_b,        // operand b
    input  wire logic [1:0] op_c,        // third operand, shared mode
    input  wire logic       carry_in,    // dedicated carry in
    input  wire logic       shared_in,   // shared arithmetic chain in
    output logic [1:0]      sum,         // adder results
    output logic            carry_out,   // dedicated carry out
    output logic            shared_out   // shared arithmetic chain out
);

    logic [1:0] lut_s;                   // partial sum tables
    logic [1:0] lut_k;                   // partial carry tables
    logic [1:0] add_x;                   // first adder operand
    logic [1:0] add_y;                   // second adder operand
    logic [1:0] r0;                      // first_cell_adder result
    logic [1:0] r1;                      // second_cell_adder result

    // four tables: sum and carry of three inputs
    assign lut_s = op_a ^ op_b ^ op_c;
    assign lut_k = (op_a & op_b) | (op_a & op_c) | (op_b & op_c);

    // operand steering per mode
    always_comb
    begin
        add_x = op_a ^ op_b;
        add_y = 2'h0;
        shared_out = 1'b0;
        unique case (mode)
            LCAC_ARITH:
            begin
                add_x = op_a;
                add_y = op_b;
            end
            LCAC_SHARED:
            begin
                add_x = lut_s;
                add_y = {lut_k[0], shared_in};
                shared_out = lut_k[1];
            end
            default:
            begin
                add_x = op_a ^ op_b;     // plain logic, no adder use
                add_y = 2'h0;
            end
        endcase
    end

    // carry in feeds adder 0, adder 0 feeds adder 1
    assign r0 = {1'b0, add_x[0]} + {1'b0, add_y[0]} + {1'b0, carry_in};
    assign r1 = {1'b0, add_x[1]} + {1'b0, add_y[1]} + {1'b0, r0[1]};

    always_comb
    begin
        if (mode == LCAC_NORMAL)
        begin
            sum = add_x;
            carry_out = carry_in;        // pass through, bypassed half
        end
        else
        begin
            sum = {r1[0], r0[0]};
            carry_out = r1[1];
        end
    end

endmodule
`default_nettype wire

// ---- lcac_cell_reg.sv ----
// Purpose: one cell register with clear, preset, sync load and enable
// Assumes: cluster clock, asynchronous controls active as named
// Notes:   device clear beats clear, clear beats preset
`timescale 1ns/1ns
`default_nettype none
module lcac_cell_reg (
    input  wire logic clk_sys,           // cluster clock
    input  wire logic rst_n,             // synchronous reset
    input  wire logic dev_clr_n,         // device wide clear, async
    input  wire logic aclr_n,            // chosen cluster clear, async
    input  wire logic apre,              // cluster preset, async
    input  wire logic ena,               // clock enable
    input  wire logic sload,             // cluster synchronous load
    input  wire logic sdata,             // synchronous load value
    input  wire logic d,                 // normal data
    output logic      q                  // register output
);

    logic arst_n;                        // merged clear term
    logic aset;                          // preset, masked by any clear

    // device clear folded in so nothing can override it
    assign arst_n = dev_clr_n & aclr_n;
    // masking gives a held preset an edge when the clear lets go,
    // so the one appears at once instead of at the next clock
    assign aset = apre & arst_n;

    // asynchronous controls first, then synchronous data path
    always_ff @(posedge clk_sys or negedge arst_n or posedge aset)
    begin
        if (!arst_n)
            q <= 1'b0;
        else if (aset)
            q <= 1'b1;                   // load of logic one
        else if (!rst_n)
            q <= 1'b0;
        else if (ena)
            q <= sload ? sdata : d;
    end

endmodule
`default_nettype wire

// ---- lcac_cluster.sv ----
// Purpose: one logic array cluster with carry, shared and register chains
// Assumes: neighbour clusters in the column drive the chain inputs
// Notes:   chain outputs to the next cluster are registered
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module lcac_cluster
    import lcac_pkg::*;
#(
    parameter int COLUMN_INDEX = 0       // even columns bypass upper half
)
(
    input  wire logic        clk_sys,            // cluster clock
    input  wire logic        rst_n,              // sync reset, active low
    input  wire logic        device_wide_clear_n, // async, clears all cell registers
    input  wire logic [3:0]  bus_addr,           // control port address
    input  wire logic [31:0] bus_wdata,          // control write data
    input  wire logic        bus_wr,             // write strobe
    input  wire logic        bus_rd,             // read strobe
    output logic [31:0]      bus_rdata_q,        // read data, next cycle
    input  wire logic [15:0] op_a,               // operand a per bit
    input  wire logic [15:0] op_b,               // operand b per bit
    input  wire logic [15:0] op_c,               // third operand
    input  wire logic        carry_in_upper,     // from cluster above
    input  wire logic        carry_in_lower,     // lower half chain in
    input  wire logic        shared_in_upper,    // shared chain in
    input  wire logic        shared_in_lower,    // shared chain in, lower
    input  wire logic [7:0]  sixth_input_upper,  // packing data, reg 0
    input  wire logic [7:0]  sixth_input_lower,  // packing data, reg 1
    input  wire logic [1:0]  aclr_n,             // two cluster clears
    input  wire logic        apre,               // cluster preset
    input  wire logic        clk_en,             // cluster clock enable
    input  wire logic        sload,              // cluster sync load
    input  wire logic [15:0] sync_data,          // sync load values
    input  wire logic        reg_chain_in,       // register chain in
    output logic [15:0]      reg_q,              // register outputs
    output logic             reg_chain_out,      // last register
    output logic             carry_out_upper_q,  // to next cluster
    output logic             carry_out_lower_q,  // to next cluster
    output logic             shared_out_upper_q, // to next cluster
    output logic             shared_out_lower_q, // to next cluster
    output logic [1:0]       carry_route_q       // final carries out
);

    // ************************************************************
    // control registers
    // ************************************************************
    logic [6:0]  ctrl_q;                 // modes, span, chain starts
    logic [31:0] dsel_q;                 // two bits per register
    logic [15:0] clrsel_q;               // which clear per register
    lcac_mode_t  mode_up;                // upper half mode
    lcac_mode_t  mode_lo;                // lower half mode
    logic        halves;                 // two independent half chains
    logic        beg_up;                 // chain starts at cell 0
    logic        beg_lo;                 // chain starts at cell 4

    assign mode_up = lcac_mode_t'(ctrl_q[LCAC_F_UMODE +: 2]);
    assign mode_lo = lcac_mode_t'(ctrl_q[LCAC_F_LMODE +: 2]);
    assign halves  = ctrl_q[LCAC_F_HALVES];
    assign beg_up  = ctrl_q[LCAC_F_BEG_U];
    assign beg_lo  = ctrl_q[LCAC_F_BEG_L];

    // which half this column lets go unused
    function automatic logic bypass_ok(input logic lower_half);
        bypass_ok = COLUMN_INDEX[0] ? lower_half : !lower_half;
    endfunction

    // software writes, one register per strobe
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctrl_q   <= LCAC_CTRL_RST;
            dsel_q   <= LCAC_DSEL_RST;
            clrsel_q <= LCAC_CLRSEL_RST;
        end
        else if (bus_wr)
        begin
            unique case (bus_addr)
                LCAC_OFS_CTRL:   ctrl_q   <= bus_wdata[6:0];
                LCAC_OFS_DSEL:   dsel_q   <= bus_wdata;
                LCAC_OFS_CLRSEL: clrsel_q <= bus_wdata[15:0];
                default:         ;       // status and holes ignore
            endcase
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || !bus_rd)
            bus_rdata_q <= 32'h0000_0000;
        else
        begin
            unique case (bus_addr)
                LCAC_OFS_CTRL:   bus_rdata_q <= {25'h0, ctrl_q};
                LCAC_OFS_DSEL:   bus_rdata_q <= dsel_q;
                LCAC_OFS_CLRSEL: bus_rdata_q <= {16'h0, clrsel_q};
                LCAC_OFS_STATUS: bus_rdata_q <= {14'h0, carry_route_q, reg_q};
                default:         bus_rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // cells and their chains
    // ************************************************************
    logic [7:0]  cin;                    // carry into each cell
    logic [7:0]  cout;                   // carry out of each cell
    logic [7:0]  shin;                   // shared chain into each cell
    logic [7:0]  shout;                  // shared chain out of each cell
    lcac_mode_t  cmode [LCAC_CELLS];     // mode per cell
    logic [15:0] sum;                    // adder results

    // chain entry points: cell 0, and cell 4 only with two half chains
    always_comb
    begin
        for (int i = 0; i < LCAC_CELLS; i++)
        begin
            cmode[i] = (i < LCAC_HALF || !halves) ? mode_up : mode_lo;
            if (i == 0)
            begin
                cin[i]  = beg_up ? 1'b0 : carry_in_upper;
                shin[i] = beg_up ? 1'b0 : shared_in_upper;
            end
            else if (i == LCAC_HALF && halves)
            begin
                cin[i]  = beg_lo ? 1'b0 : carry_in_lower;
                shin[i] = beg_lo ? 1'b0 : shared_in_lower;
            end
            else
            begin
                cin[i]  = cout[i-1];
                shin[i] = shout[i-1];
            end
        end
    end

    // eight cells, two adders each
    generate
        for (genvar g = 0; g < LCAC_CELLS; g++)
        begin : g_cell
            lcac_cell_adders u_add (
                .mode       (cmode[g]),
                .op_a       (op_a[2*g +: 2]),
                .op_b       (op_b[2*g +: 2]),
                .op_c       (op_c[2*g +: 2]),
                .carry_in   (cin[g]),
                .shared_in  (shin[g]),
                .sum        (sum[2*g +: 2]),
                .carry_out  (cout[g]),
                .shared_out (shout[g])
            );
        end
    endgenerate

    // ************************************************************
    // links to the next cluster and to routing
    // ************************************************************
    logic co_up_d;                       // next carry out, upper
    logic co_lo_d;                       // next carry out, lower
    logic so_up_d;                       // next shared out, upper
    logic so_lo_d;                       // next shared out, lower
    logic [1:0] route_d;                 // next routed carries

    // a used half feeds onward; an unused half may pass through
    always_comb
    begin
        co_lo_d = 1'b0;
        so_lo_d = 1'b0;
        route_d = 2'h0;
        if (!halves)
        begin
            co_up_d = cout[7];           // 16 bit chain, next cell 0
            so_up_d = shout[7];
            route_d[0] = cout[7];
        end
        else
        begin
            if (mode_up != LCAC_NORMAL)
            begin
                co_up_d = cout[3];
                so_up_d = shout[3];
                route_d[0] = cout[3];
            end
            else
            begin
                co_up_d = bypass_ok(1'b0) & carry_in_upper;
                so_up_d = bypass_ok(1'b0) & shared_in_upper;
            end
            if (mode_lo != LCAC_NORMAL)
            begin
                co_lo_d = cout[7];
                so_lo_d = shout[7];
                route_d[1] = cout[7];
            end
            else
            begin
                co_lo_d = bypass_ok(1'b1) & carry_in_lower;
                so_lo_d = bypass_ok(1'b1) & shared_in_lower;
            end
        end
    end

    // registered so every output leaves from a flop; costs a cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            carry_out_upper_q  <= 1'b0;
            carry_out_lower_q  <= 1'b0;
            shared_out_upper_q <= 1'b0;
            shared_out_lower_q <= 1'b0;
            carry_route_q      <= 2'h0;
        end
        else
        begin
            carry_out_upper_q  <= co_up_d;
            carry_out_lower_q  <= co_lo_d;
            shared_out_upper_q <= so_up_d;
            shared_out_lower_q <= so_lo_d;
            carry_route_q      <= route_d;
        end
    end

    // ************************************************************
    // cell registers
    // ************************************************************
    logic [15:0] reg_d;                  // chosen normal data

    // data source per register: sum, chain or packed sixth input
    always_comb
    begin
        for (int r = 0; r < LCAC_BITS; r++)
        begin
            unique case (lcac_dsel_t'(dsel_q[2*r +: 2]))
                LCAC_D_CHAIN:
                    reg_d[r] = (r == 0) ? reg_chain_in : reg_q[r-1];
                LCAC_D_PACK:
                    reg_d[r] = r[0] ? sixth_input_lower[r/2]
                                    : sixth_input_upper[r/2];
                default:
                    reg_d[r] = sum[r];
            endcase
        end
    end

    generate
        for (genvar r = 0; r < LCAC_BITS; r++)
        begin : g_reg
            lcac_cell_reg u_reg (
                .clk_sys   (clk_sys),
                .rst_n     (rst_n),
                .dev_clr_n (device_wide_clear_n),
                .aclr_n    (aclr_n[clrsel_q[r]]),
                .apre      (apre),
                .ena       (clk_en),
                .sload     (sload),
                .sdata     (sync_data[r]),
                .d         (reg_d[r]),
                .q         (reg_q[r])
            );
        end
    endgenerate

    assign reg_chain_out = reg_q[15];

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    logic quiet;                         // no asynchronous control active
    assign quiet = device_wide_clear_n & (&aclr_n) & !apre;

    a_chain_start: assert property (
        beg_up |-> cin[0] == 1'b0 && shin[0] == 1'b0)
        else $error("chain did not start at zero");
    a_full_link: assert property (!halves |-> cin[4] == cout[3])
        else $error("full chain broken at cell 4");
    a_carry_next: assert property (
        !halves |=> carry_out_upper_q == $past(cout[7]))
        else $error("carry to next cluster wrong");
    a_half_cont: assert property (
        halves && mode_lo != LCAC_NORMAL
        |=> carry_out_lower_q == $past(cout[7]))
        else $error("lower half carry not continued");
    a_no_bypass: assert property (
        halves && mode_up == LCAC_NORMAL && !bypass_ok(1'b0)
        |=> carry_out_upper_q == 1'b0)
        else $error("upper half bypassed in wrong column");
    // the half that this column may not bypass must block its carry
    a_no_bypass_lo: assert property (
        halves && mode_lo == LCAC_NORMAL && !bypass_ok(1'b1)
        |=> carry_out_lower_q == 1'b0)
        else $error("lower half bypassed in wrong column");
    a_arith_sum: assert property (
        !halves && beg_up && mode_up == LCAC_ARITH
        |-> sum == 16'(op_a + op_b))
        else $error("arithmetic sum wrong");
    a_three_add: assert property (
        !halves && beg_up && mode_up == LCAC_SHARED
        |-> sum == 16'(op_a + op_b + op_c))
        else $error("three operand sum wrong");
    a_reg_shift: assert property (
        quiet && clk_en && !sload && dsel_q[3:2] == LCAC_D_CHAIN
        ##1 quiet |-> reg_q[1] == $past(reg_q[0]))
        else $error("register chain did not shift");
    a_clear_wins: assert property (
        !aclr_n[clrsel_q[0]] && apre |-> reg_q[0] == 1'b0)
        else $error("clear lost to preset");
    a_preset_one: assert property (
        apre && device_wide_clear_n && aclr_n[clrsel_q[0]]
        |-> reg_q[0] == 1'b1)
        else $error("preset did not load one");
    a_dev_clear: assert property (
        !device_wide_clear_n |-> reg_q == 16'h0000)
        else $error("device clear did not reset");
    a_sync_load: assert property (
        quiet && clk_en && sload ##1 quiet |-> reg_q == $past(sync_data))
        else $error("sync load value not taken");

    c_full_shared: cover property (
        !halves && mode_up == LCAC_SHARED && cout[7]);
    c_half_chains: cover property (halves && mode_up == LCAC_ARITH
        && mode_lo == LCAC_ARITH);
    c_bypass: cover property (halves && mode_up == LCAC_NORMAL
        && carry_out_upper_q);
    c_shift: cover property (dsel_q[3:2] == LCAC_D_CHAIN && reg_q[1]);

endmodule
`default_nettype wire

// ---- lcac_nbr.sv ----
// Purpose: neighbour cluster above, feeds chain inputs
// Assumes: its chain outputs are registered
// Notes:   values come from the bench
`timescale 1ns/1ns
`default_nettype none
module lcac_nbr (
    input  wire logic       clk_sys, // shared clock
    input  wire logic [4:0] want_d,  // carry u/l, shared u/l, reg
    output logic [4:0]      chain_q  // registered like a real cluster
);
    // one cycle per cluster, so the bench waits an extra edge
    always_ff @(posedge clk_sys)
    begin
        chain_q <= want_d;
    end
endmodule
`default_nettype wire

// ---- tb.sv ----
// Purpose: self-checking bench for one cluster
// Assumes: even column, upper half bypassable
// Notes:   async controls checked between edges
`timescale 1ns/1ns
`default_nettype none
module tb import lcac_pkg::*;;
    logic        clk_sys, rst_n, dclr_n, wr, rd, apre, en, sload;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata;
    logic [15:0] a, b, c, sdat, q;
    logic [7:0]  pk_u, pk_l;
    logic [1:0]  aclr_n, route;
    logic [4:0]  want, ch;
    logic        cou, col, sou, sol, rco;
    int          failures, check_count;
    lcac_nbr NBR (.clk_sys(clk_sys), .want_d(want), .chain_q(ch));
    lcac_cluster #(.COLUMN_INDEX(0)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .device_wide_clear_n(dclr_n), .bus_addr(addr), .bus_wdata(wdata),
        .bus_wr(wr), .bus_rd(rd), .bus_rdata_q(rdata), .op_a(a), .op_b(b),
        .op_c(c), .carry_in_upper(ch[4]), .carry_in_lower(ch[3]),
        .shared_in_upper(ch[2]), .shared_in_lower(ch[1]),
        .sixth_input_upper(pk_u), .sixth_input_lower(pk_l),
        .aclr_n(aclr_n), .apre(apre), .clk_en(en), .sload(sload),
        .sync_data(sdat), .reg_chain_in(ch[0]), .reg_q(q),
        .reg_chain_out(rco), .carry_out_upper_q(cou),
        .carry_out_lower_q(col), .shared_out_upper_q(sou),
        .shared_out_lower_q(sol), .carry_route_q(route));
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic wr32(input logic [3:0] ad, input logic [31:0] d);
        @(posedge clk_sys);
        {wr, addr, wdata} <= {1'b1, ad, d};
        @(posedge clk_sys);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd32(input logic [3:0] ad, input logic [31:0] exp);
        @(posedge clk_sys);
        {rd, addr} <= {1'b1, ad};
        @(posedge clk_sys);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    // extra edge lets the neighbour's registered chain land
    task automatic ops(input logic [15:0] x, y, z, input logic [4:0] w);
        @(posedge clk_sys);
        {a, b, c, want} <= {x, y, z, w};
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic t_carry();
        wr32(LCAC_OFS_CTRL, 32'h61);
        ops(16'h1, 16'hffff, 16'h0, 5'h10);
        chk({q, cou, route}, {16'h0, 1'b1, 2'b01});
        wr32(LCAC_OFS_CTRL, 32'h01);
        ops(16'h0, 16'hffff, 16'h0, 5'h10);
        chk({q, cou}, {16'h0, 1'b1});
        rd32(LCAC_OFS_STATUS, 32'h0001_0000);
        wr32(LCAC_OFS_CTRL, 32'h14);
        ops(16'h0, 16'hff00, 16'h0, 5'h18);
        chk({q, cou, col}, {16'h0, 2'b11});
        wr32(LCAC_OFS_CTRL, 32'h11);
        ops(16'h1, 16'hff, 16'h0, 5'h08);
        chk({q, cou, col, route}, {16'h0, 2'b10, 2'b01});
    endtask
    task automatic t_shared();
        wr32(LCAC_OFS_CTRL, 32'h62);
        ops(16'h1234, 16'h0f0f, 16'h00ff, 5'h0);
        chk(q, 16'h2242);
        wr32(LCAC_OFS_CTRL, 32'h18);
        ops(16'h8000, 16'h8000, 16'h0, 5'h06);
        chk({q, sou, sol, cou, col}, {16'h0100, 4'b1100});
        wr32(LCAC_OFS_DSEL, 32'haaaa_aaaa);
        ops(16'h0, 16'h0, 16'h0, 5'h0);
        chk(q, 16'h5555);
        wr32(LCAC_OFS_DSEL, 32'h5555_5555);
        ops(16'h0, 16'h0, 16'h0, 5'h1);
        chk({q, rco}, {16'haaa9, 1'b1});
    endtask
    task automatic t_async();
        wr32(LCAC_OFS_CLRSEL, 32'hff00);
        @(posedge clk_sys);
        {apre, en} <= 2'b10;
        #1 chk(q, 16'hffff);
        @(posedge clk_sys);
        aclr_n <= 2'b10;
        #1 chk(q, 16'hff00);
        @(posedge clk_sys);
        {aclr_n, dclr_n} <= 3'b110;
        #1 chk(q, 16'h0);
        @(posedge clk_sys);
        {apre, dclr_n, sload, sdat} <= {3'b011, 16'ha5a5};
        @(posedge clk_sys);
        en <= 1'b1;
        #1 chk(q, 16'h0);
        @(posedge clk_sys);
        #1 chk(q, 16'ha5a5);
        @(posedge clk_sys);
        sload <= 1'b0;
        #1 chk(q, 16'ha5a5);
    endtask
    task automatic stop_test();
        $display("failures=%0d checks=%0d", failures, check_count);
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        {rst_n, wr, rd, apre, sload, addr, wdata, a, b, c, sdat, want} = '0;
        {dclr_n, en, aclr_n, pk_u, pk_l} = {4'hf, 8'hff, 8'h0};
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd32(LCAC_OFS_CTRL, 32'h60);
        rd32(4'h2, 32'h0);
        t_carry();
        t_shared();
        t_async();
        stop_test();
    end
    // watchdog well past the expected run length
    initial
    begin
        #40000;
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
